// ---- include/dflc_pkg.sv ----
// ---------------------------------------------------------------------------
// Shared constants for the duty input and fault log counter bank.
// ---------------------------------------------------------------------------
package dflc_pkg;

   // Clock rate and the run time tick.
   localparam int unsigned CLOCK_PERIOD_NS = 10;
   localparam int unsigned RUN_TICK_MS     = 1;
   localparam int unsigned RUN_TICK_CYCLES = (RUN_TICK_MS * 1000000) / CLOCK_PERIOD_NS;
   localparam int unsigned MS_DIV_WIDTH    = 17;

   // Duty measurement: full duty is two to the thirteenth.
   localparam int unsigned      DUTY_SCALE_BITS    = 13;
   localparam int unsigned      DUTY_WIDTH         = 16;
   localparam int unsigned      RAW_WIDTH          = DUTY_SCALE_BITS + 1;
   localparam logic [13:0]      DUTY_FULL_SCALE    = 14'h2000;
   localparam logic [12:0]      WINDOW_LAST_SAMPLE = 13'h1fff;
   localparam logic signed [16:0] DUTY_FULL_SIGNED = 17'sh02000;
   localparam int unsigned      SAMPLE_DIV_DEFAULT = 4;
   localparam int unsigned      SAMPLE_DIV_WIDTH   = 8;

   // Counter widths and saturation values.
   localparam int unsigned RUNTIME_WIDTH = 48;
   localparam int unsigned COUNT_WIDTH   = 16;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;
   localparam logic [47:0] RUNTIME_MAX   = 48'hffff_ffff_ffff;

   // Event slots of the fault log.
   localparam int unsigned EVENT_COUNT  = 5;
   localparam int unsigned EV_RESET     = 0;
   localparam int unsigned EV_INTERNAL  = 1;
   localparam int unsigned EV_SHORT     = 2;
   localparam int unsigned EV_OVERSHOOT = 3;
   localparam int unsigned EV_UNDERVOLT = 4;

   // Parameter numbers as seen by the network master.
   localparam logic [7:0] OFS_APPLIED_DUTY   = 8'h68;
   localparam logic [7:0] OFS_RAW_DUTY       = 8'h69;
   localparam logic [7:0] OFS_RUN_TIME       = 8'h94;
   localparam logic [7:0] OFS_RESET_COUNT    = 8'h95;
   localparam logic [7:0] OFS_INTERNAL_COUNT = 8'h96;
   localparam logic [7:0] OFS_SHORT_COUNT    = 8'h97;
   localparam logic [7:0] OFS_OVERSHOOT_CNT  = 8'h98;
   localparam logic [7:0] OFS_UNDERVOLT_CNT  = 8'h99;

endpackage : dflc_pkg

// ---- rtl/dflc_duty_meter.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Duty meter: counts high samples of the command pin over a fixed window.
// ---------------------------------------------------------------------------
module dflc_duty_meter #(
   parameter int unsigned SampleDiv = dflc_pkg::SAMPLE_DIV_DEFAULT
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        pwmPin,
   input  wire logic        dirPin,
   output logic      [15:0] rawDuty,
   output logic             dirLevel,
   output logic             dutyUpdate
);

   typedef struct packed {
      logic [1:0]  pwmSync;
      logic [1:0]  dirSync;
      logic [7:0]  divCount;
      logic [12:0] sampleCount;
      logic [13:0] highCount;
      logic [15:0] rawDuty;
      logic        update;
   } dflc_meter_s;

   dflc_meter_s st;
   dflc_meter_s next_st;
   logic [13:0] sum;

   // A window of exactly two to the thirteenth samples makes the high count
   // the duty in its final scale, so no divider is needed.
   always_comb begin
      next_st            = st;
      sum                = st.highCount + {13'h0000, st.pwmSync[1]};
      next_st.pwmSync    = {st.pwmSync[0], pwmPin};
      next_st.dirSync    = {st.dirSync[0], dirPin};
      next_st.update     = 1'b0;
      if (st.divCount == 8'(SampleDiv - 1)) begin
         next_st.divCount = 8'h00;
         if (st.sampleCount == dflc_pkg::WINDOW_LAST_SAMPLE) begin
            next_st.rawDuty     = {2'b00, sum};
            next_st.highCount   = 14'h0000;
            next_st.sampleCount = 13'h0000;
            next_st.update      = 1'b1;
         end else begin
            next_st.highCount   = sum;
            next_st.sampleCount = st.sampleCount + 13'h0001;
         end
      end else begin
         next_st.divCount = st.divCount + 8'h01;
      end
   end

   // State register; the first synchroniser stage feeds only the second.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rawDuty    = st.rawDuty;
   assign dirLevel   = st.dirSync[1];
   assign dutyUpdate = st.update;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_raw_range: assert property (rawDuty <= {2'b00, dflc_pkg::DUTY_FULL_SCALE})
      else $error("raw duty above full scale");

endmodule : dflc_duty_meter

// ---- rtl/dflc_top.sv ----
`timescale 1ns/10ps
module dflc_top #(
   parameter int unsigned MsTickCycles = dflc_pkg::RUN_TICK_CYCLES,
   parameter int unsigned SampleDiv    = dflc_pkg::SAMPLE_DIV_DEFAULT
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        pwmPin,
   input  wire logic        dirPin,
   input  wire logic        cfgPwmMode,
   input  wire logic        cfgBipolar,
   input  wire logic        cfgInvert,
   input  wire logic        faultReset,
   input  wire logic        faultInternal,
   input  wire logic        faultShort,
   input  wire logic        faultOvershoot,
   input  wire logic        faultUndervolt,
   input  wire logic        paramRead,
   input  wire logic        paramWrite,
   input  wire logic [7:0]  paramIndex,
   output logic      [47:0] paramData,
   output logic             paramValid,
   output logic             paramError
);

   // ------------------------------------------------------------------------
   // State and helpers
   // ------------------------------------------------------------------------

   typedef struct packed {
      logic [4:0]       prevFault;
      logic [4:0][15:0] eventCount;
      logic [16:0]      msDiv;
      logic [47:0]      runTime;
      logic [15:0]      appliedDuty;
      logic [47:0]      respData;
      logic             respValid;
      logic             respError;
   } dflc_state_s;

   dflc_state_s st;
   dflc_state_s next_st;
   logic [4:0]  faultVec;
   logic [15:0] rawDuty;
   logic        dirLevel;
   logic        dutyUpdate;
   logic        msTick;

   // Saturating step of one event counter.
   function automatic logic [15:0] satInc(input logic [15:0] value);
      logic [15:0] result;
      result = value;
      if (value != dflc_pkg::COUNT_MAX) begin
         result = value + 16'h0001;
      end
      return result;
   endfunction : satInc

   // Signed duty from the raw measurement and the configured handling.
   function automatic logic [15:0] applyPolarity(input logic [15:0] raw,
                                                 input logic        bipolar,
                                                 input logic        dirHigh,
                                                 input logic        invert);
      logic signed [16:0] mag;
      logic signed [16:0] val;
      mag = $signed({3'b000, raw[13:0]});
      if (bipolar) begin
         val = (mag <<< 1) - dflc_pkg::DUTY_FULL_SIGNED;
      end else if (dirHigh) begin
         val = mag;
      end else begin
         val = -mag;
      end
      if (invert) begin
         val = -val;
      end
      return 16'(val);
   endfunction : applyPolarity

   assign faultVec = {faultUndervolt, faultOvershoot, faultShort, faultInternal, faultReset};
   assign msTick   = (st.msDiv == 17'(MsTickCycles - 1));

   // ------------------------------------------------------------------------
   // Duty measurement
   // ------------------------------------------------------------------------

   // The meter owns the pin synchronisers, so the pwm and direction pins pass two flops.
   dflc_duty_meter #(
      .SampleDiv (SampleDiv)
   ) u_meter (
      .clock      (clock),
      .rst_n      (rst_n),
      .pwmPin     (pwmPin),
      .dirPin     (dirPin),
      .rawDuty    (rawDuty),
      .dirLevel   (dirLevel),
      .dutyUpdate (dutyUpdate)
   );

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------

   // Counters, run time, duty processing and the parameter answer.
   always_comb begin
      next_st           = st;
      next_st.prevFault = faultVec;

      // Fault flags are levels; only a rising edge is one occurrence.
      for (int i = 0; i < int'(dflc_pkg::EVENT_COUNT); i++) begin
         if (faultVec[i] && !st.prevFault[i]) begin
            next_st.eventCount[i] = satInc(st.eventCount[i]);
         end
      end

      // The divider restarts on every tick, so the tick spacing never drifts.
      // millisecond run time
      if (msTick) begin
         next_st.msDiv = 17'h00000;
         if (st.runTime != dflc_pkg::RUNTIME_MAX) begin
            next_st.runTime = st.runTime + 48'h0000_0000_0001;
         end
      end else begin
         next_st.msDiv = st.msDiv + 17'h00001;
      end

      // Applied duty lags the raw value by one cycle, so a read in that cycle
      // still returns the value built from the previous window.
      // signed applied duty
      if (cfgPwmMode) begin
         next_st.appliedDuty = applyPolarity(rawDuty, cfgBipolar, dirLevel, cfgInvert);
      end else begin
         next_st.appliedDuty = 16'h0000;
      end

      // Answers last one cycle; writes are refused, nothing is stored.
      next_st.respValid = paramRead | paramWrite;
      next_st.respError = 1'b0;
      next_st.respData  = 48'h0000_0000_0000;
      if (paramWrite) begin
         next_st.respError = 1'b1;
      end else if (paramRead) begin
         unique case (paramIndex)
            dflc_pkg::OFS_APPLIED_DUTY: begin
               next_st.respData = {32'h0000_0000, st.appliedDuty};
            end
            dflc_pkg::OFS_RAW_DUTY: begin
               next_st.respData = {32'h0000_0000, rawDuty};
            end
            dflc_pkg::OFS_RUN_TIME: begin
               next_st.respData = st.runTime;
            end
            dflc_pkg::OFS_RESET_COUNT: begin
               next_st.respData = {32'h0000_0000, st.eventCount[dflc_pkg::EV_RESET]};
            end
            dflc_pkg::OFS_INTERNAL_COUNT: begin
               next_st.respData = {32'h0000_0000, st.eventCount[dflc_pkg::EV_INTERNAL]};
            end
            dflc_pkg::OFS_SHORT_COUNT: begin
               next_st.respData = {32'h0000_0000, st.eventCount[dflc_pkg::EV_SHORT]};
            end
            dflc_pkg::OFS_OVERSHOOT_CNT: begin
               next_st.respData = {32'h0000_0000, st.eventCount[dflc_pkg::EV_OVERSHOOT]};
            end
            dflc_pkg::OFS_UNDERVOLT_CNT: begin
               next_st.respData = {32'h0000_0000, st.eventCount[dflc_pkg::EV_UNDERVOLT]};
            end
            default: begin
               next_st.respError = 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------------

   // Counters live in flops only, so every reset starts them from zero.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign paramData  = st.respData;
   assign paramValid = st.respValid;
   assign paramError = st.respError;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_applied_duty_range: assert property (
      ($signed(st.appliedDuty) <= 16'sh2000) && ($signed(st.appliedDuty) >= -16'sh2000))
      else $error("applied duty outside signed full scale");

   a_bipolar_inverted_map: assert property (
      (cfgPwmMode && cfgBipolar && cfgInvert && $stable(rawDuty))
      |=> ($signed(st.appliedDuty) == 16'sh2000 - 16'($signed({2'b00, $past(rawDuty[13:0])}) <<< 1)))
      else $error("inverted bipolar duty does not match raw duty");

   // The meter raises its update flag in the same cycle as the new raw value,
   // so the change and the flag are compared in one cycle.
   // raw changes only at a window end
   a_raw_only_on_window: assert property (
      !dutyUpdate |-> $stable(rawDuty))
      else $error("raw duty moved outside a window end");

   a_run_time_step: assert property (
      (msTick && (st.runTime != dflc_pkg::RUNTIME_MAX)) |=> (st.runTime == $past(st.runTime) + 48'h1))
      else $error("run time did not advance on the millisecond tick");

   a_run_time_hold: assert property (
      !msTick |=> $stable(st.runTime))
      else $error("run time changed between ticks");

   a_reset_event_count: assert property (
      (faultReset && !st.prevFault[0] && (st.eventCount[0] != dflc_pkg::COUNT_MAX))
      |=> (st.eventCount[0] == $past(st.eventCount[0]) + 16'h0001))
      else $error("drive reset occurrence not counted");

   a_short_event_count: assert property (
      (faultShort && !st.prevFault[2] && (st.eventCount[2] != dflc_pkg::COUNT_MAX))
      |=> (st.eventCount[2] == $past(st.eventCount[2]) + 16'h0001) ##1 $stable(st.eventCount[2]))
      else $error("short circuit occurrence not counted once");

   a_count_saturates: assert property (
      (st.eventCount[4] == dflc_pkg::COUNT_MAX) |=> (st.eventCount[4] == dflc_pkg::COUNT_MAX))
      else $error("undervoltage counter wrapped");

   a_write_ignored: assert property (
      (paramWrite && (faultVec == st.prevFault)) |=> ($stable(st.eventCount) && paramError && paramValid))
      else $error("network write changed a counter or was not refused");

   a_internal_event_count: assert property (
      (faultInternal && !st.prevFault[dflc_pkg::EV_INTERNAL]
         && (st.eventCount[dflc_pkg::EV_INTERNAL] != dflc_pkg::COUNT_MAX))
      |=> (st.eventCount[dflc_pkg::EV_INTERNAL] == $past(st.eventCount[dflc_pkg::EV_INTERNAL]) + 16'h0001))
      else $error("internal error occurrence not counted");

   a_overshoot_event_count: assert property (
      (faultOvershoot && !st.prevFault[dflc_pkg::EV_OVERSHOOT]
         && (st.eventCount[dflc_pkg::EV_OVERSHOOT] != dflc_pkg::COUNT_MAX))
      |=> (st.eventCount[dflc_pkg::EV_OVERSHOOT] == $past(st.eventCount[dflc_pkg::EV_OVERSHOOT]) + 16'h0001))
      else $error("current overshoot occurrence not counted");

   a_undervolt_event_count: assert property (
      (faultUndervolt && !st.prevFault[dflc_pkg::EV_UNDERVOLT]
         && (st.eventCount[dflc_pkg::EV_UNDERVOLT] != dflc_pkg::COUNT_MAX))
      |=> (st.eventCount[dflc_pkg::EV_UNDERVOLT] == $past(st.eventCount[dflc_pkg::EV_UNDERVOLT]) + 16'h0001))
      else $error("undervoltage occurrence not counted");

   a_raw_read_answer: assert property (
      (paramRead && !paramWrite && (paramIndex == dflc_pkg::OFS_RAW_DUTY))
      |=> (paramValid && !paramError && (paramData == {32'h0000_0000, $past(rawDuty)})))
      else $error("raw duty read answered a wrong value");

   a_applied_off_mode: assert property (
      !cfgPwmMode |=> (st.appliedDuty == 16'h0000))
      else $error("applied duty not zero outside command mode");

   // Main scenarios that the bench is expected to reach.
   c_read_run_time: cover property (paramRead && !paramWrite && (paramIndex == dflc_pkg::OFS_RUN_TIME));
   c_duty_update: cover property (dutyUpdate && cfgPwmMode && !cfgBipolar);
   c_overshoot_event: cover property (faultOvershoot && !st.prevFault[3]);
   c_unmapped_read: cover property (paramValid && paramError);
   c_applied_negative: cover property (cfgPwmMode && ($signed(st.appliedDuty) < 16'sh0000));

endmodule : dflc_top

// ---- tb/dflc_net_master.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Network master model: one parameter request at a time.
// ---------------------------------------------------------------------------
module dflc_net_master (
   input  wire logic        clock,
   output logic             paramRead,
   output logic             paramWrite,
   output logic      [7:0]  paramIndex,
   input  wire logic [47:0] paramData,
   input  wire logic        paramValid,
   input  wire logic        paramError
);
   // The bus starts idle.
   initial begin
      paramRead  = 1'b0;
      paramWrite = 1'b0;
      paramIndex = 8'h00;
   end

   // Launch at a falling edge; the answer stands in the cycle after the taking edge.
   // A released index shows the inverse of the last one; read and write are low then, so it is never taken.
   task automatic access(input logic wr, input logic [7:0] idx, output logic [47:0] data,
                         output logic valid, output logic err);
      @(negedge clock);
      paramRead  = ~wr;
      paramWrite = wr;
      paramIndex = idx;
      @(negedge clock);
      paramRead  = 1'b0;
      paramWrite = 1'b0;
      paramIndex = ~idx;
      data       = paramData;
      valid      = paramValid;
      err        = paramError;
   endtask : access
endmodule : dflc_net_master

// ---- tb/test_duty_input_and_fault_log_counters.sv ----
`timescale 1ns/10ps
module test_duty_input_and_fault_log_counters;
   // Short run time tick and one sample per cycle keep the run brief.
   localparam int unsigned TickCycles = 10;
   localparam int unsigned CycleLimit = 80000;

   logic        clock      = 1'b0;
   logic        rst_n      = 1'b0;
   logic        pwmPin     = 1'b0;
   logic [1:0]  pwmSel     = 2'h0;
   logic        dirPin     = 1'b0;
   logic        cfgPwmMode = 1'b0;
   logic        cfgBipolar = 1'b0;
   logic        cfgInvert  = 1'b0;
   logic [4:0]  faults     = 5'h00;
   logic        paramRead;
   logic        paramWrite;
   logic [7:0]  paramIndex;
   logic [47:0] paramData;
   logic        paramValid;
   logic        paramError;
   int          nErrors    = 0;
   int          numChecks  = 0;
   int          cycles     = 0;
   logic [7:0]  allIdx [8] = '{8'h68, 8'h69, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99};

   // ---------------------------------------------------------------------------
   // Clock, pin waveform and hang guard
   // ---------------------------------------------------------------------------
   // Clock of 10 ns.
   always #5 clock = ~clock;

   // Pin is low, high, or toggles every cycle for an exact half duty.
   always @(negedge clock) begin
      pwmPin <= (pwmSel == 2'h2) ? ~pwmPin : pwmSel[0];
   end

   // A hang counts as a mismatch and ends the run.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == CycleLimit) begin
         nErrors = nErrors + 1;
         report_and_stop();
      end
   end

   dflc_top #(
      .MsTickCycles(TickCycles),
      .SampleDiv   (1)
   ) uut (
      .clock         (clock),
      .rst_n         (rst_n),
      .pwmPin        (pwmPin),
      .dirPin        (dirPin),
      .cfgPwmMode    (cfgPwmMode),
      .cfgBipolar    (cfgBipolar),
      .cfgInvert     (cfgInvert),
      .faultReset    (faults[0]),
      .faultInternal (faults[1]),
      .faultShort    (faults[2]),
      .faultOvershoot(faults[3]),
      .faultUndervolt(faults[4]),
      .paramRead     (paramRead),
      .paramWrite    (paramWrite),
      .paramIndex    (paramIndex),
      .paramData     (paramData),
      .paramValid    (paramValid),
      .paramError    (paramError)
   );

   dflc_net_master master (
      .clock     (clock),
      .paramRead (paramRead),
      .paramWrite(paramWrite),
      .paramIndex(paramIndex),
      .paramData (paramData),
      .paramValid(paramValid),
      .paramError(paramError)
   );

   // ---------------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------------
   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] expected);
      numChecks++;
      if (seen !== expected) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", name, expected, seen);
      end
   endtask : check

   task automatic rd(input logic [7:0] idx, input logic [47:0] expected, input string name);
      logic [47:0] data;
      logic        valid;
      logic        err;
      master.access(1'b0, idx, data, valid, err);
      check({name, " valid"}, {47'h0, valid}, 48'h1);
      check({name, " error"}, {47'h0, err}, 48'h0);
      check(name, data, expected);
   endtask : rd

   task automatic refused(input logic wr, input logic [7:0] idx);
      logic [47:0] data;
      logic        valid;
      logic        err;
      master.access(wr, idx, data, valid, err);
      check("refused valid", {47'h0, valid}, 48'h1);
      check("refused error", {47'h0, err}, 48'h1);
      check("refused data", data, 48'h0);
   endtask : refused

   task automatic report_and_stop();
      if (nErrors == 0 && numChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   // ---------------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------------
   // Counters and duty values start at zero; indices beside the map are refused.
   task automatic test_idle();
      for (int j = 0; j < 5; j++) begin
         rd(8'h95 + 8'(j), 48'h0, "event count at start");
      end
      rd(8'h68, 48'h0, "applied duty at start");
      rd(8'h69, 48'h0, "raw duty at start");
      refused(1'b0, 8'h67);
      refused(1'b0, 8'h9a);
   endtask : test_idle

   // A flag held high counts once; every slot counts alone.
   task automatic test_fault_counts();
      for (int i = 0; i < 5; i++) begin
         @(negedge clock);
         faults[i] = 1'b1;
         repeat (3) @(negedge clock);
         faults[i] = 1'b0;
         @(negedge clock);
         faults[i] = 1'b1;
         @(negedge clock);
         faults[i] = 1'b0;
         for (int j = 0; j < 5; j++) begin
            rd(8'h95 + 8'(j), (j <= i) ? 48'h2 : 48'h0, "event count");
         end
      end
   endtask : test_fault_counts

   // Writes to every place are refused and leave the counts alone.
   task automatic test_writes_refused();
      foreach (allIdx[n]) begin
         refused(1'b1, allIdx[n]);
      end
      for (int j = 0; j < 5; j++) begin
         rd(8'h95 + 8'(j), 48'h2, "event count after write");
      end
   endtask : test_writes_refused

   // Run time advances one per tick over exactly 100 cycles, writes in between.
   task automatic test_run_time();
      logic [47:0] t1;
      logic [47:0] t2;
      logic        v;
      logic        e;
      master.access(1'b0, 8'h94, t1, v, e);
      repeat (49) refused(1'b1, 8'h94);
      master.access(1'b0, 8'h94, t2, v, e);
      check("run time error", {47'h0, e}, 48'h0);
      check("run time step", t2 - t1, 48'(100 / TickCycles));
   endtask : test_run_time

   // One pin waveform, every mode, polarity, inversion and direction combination.
   task automatic test_duty(input logic [1:0] sel, input int raw);
      int v;
      pwmSel <= sel;
      repeat (2 * 8192 + 8) @(negedge clock);
      for (int k = 0; k < 16; k++) begin
         {cfgPwmMode, cfgBipolar, cfgInvert, dirPin} <= k[3:0];
         repeat (4) @(negedge clock);
         v = !k[3] ? 0 : (k[2] ? 2 * raw - 8192 : (k[0] ? raw : -raw));
         if (k[3] && k[1]) begin
            v = -v;
         end
         rd(8'h68, {32'h0, v[15:0]}, "applied duty");
         rd(8'h69, 48'(raw), "raw duty");
      end
   endtask : test_duty

   // Main sequence: reset for 10 cycles, then every scenario.
   initial begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      test_idle();
      test_fault_counts();
      test_writes_refused();
      test_run_time();
      test_duty(2'h1, 8192);
      test_duty(2'h2, 4096);
      test_duty(2'h0, 0);
      report_and_stop();
   end
endmodule : test_duty_input_and_fault_log_counters
